// ---- hw/event_action_sequencer_pkg.sv ----
/*
  Constants and types shared by the event/action sequencer and its program store.
  Assumes a single 50 MHz clock domain.
*/
package event_action_sequencer_pkg;

  localparam int MAX_PAIRS_DEF = 20;
  localparam int COUNT_W       = 5;
  localparam int CODE_W        = 8;
  localparam int PAIR_W        = 2 * CODE_W;
  localparam int PCT_W         = 7;
  localparam int TIMER_W       = 16;
  localparam int SYNC_BITS     = 3;

  localparam logic [PCT_W-1:0] PCT_MAX = 7'h64;

  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

  // Event selector codes.
  localparam logic [CODE_W-1:0] EV_FALSE      = 8'h00;
  localparam logic [CODE_W-1:0] EV_TRUE       = 8'h01;
  localparam logic [CODE_W-1:0] EV_AT_REF     = 8'h04;
  localparam logic [CODE_W-1:0] EV_TIMEOUT0   = 8'h1E;

  // Action selector codes.
  localparam logic [CODE_W-1:0] ACT_NONE      = 8'h01;
  localparam logic [CODE_W-1:0] ACT_PRESET0   = 8'h0A;
  localparam logic [CODE_W-1:0] ACT_PRESET1   = 8'h0B;
  localparam logic [CODE_W-1:0] ACT_START_TMR = 8'h1D;

  localparam logic [PCT_W-1:0]   SPEED_RESET = 7'h00;
  localparam logic [TIMER_W-1:0] TIMER_ZERO  = 16'h0000;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_FETCH = 2'b01,
    SEQ_READY = 2'b10
  } seq_state_type;

endpackage : event_action_sequencer_pkg

// ---- hw/seq_prog_if.sv ----
/*
  Interface between the sequencer control and its program store.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

interface seq_prog_if #(
  parameter int AW = 5,
  parameter int DW = 16
);
  logic          wrEn;
  logic [AW-1:0] wrAddr;
  logic [DW-1:0] wrData;
  logic [AW-1:0] rdAddr;
  logic [DW-1:0] rdData;

  modport store (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
  modport ctrl  (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
endinterface : seq_prog_if

`default_nettype wire

// ---- hw/program_store.sv ----
/*
  Event/action pair memory with a registered read port.
  Assumes writes and reads come from the same clock domain.
*/
`timescale 1ns/100ps
`default_nettype none

module program_store #(
  parameter int DEPTH = 20,
  parameter int AW    = 5,
  parameter int DW    = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  seq_prog_if.store port
);

  logic [DW-1:0] mem [DEPTH];
  logic [DW-1:0] rdData_reg;

  if (DEPTH < 1 || DEPTH > (1 << AW)) begin : badDepth
    $error("program_store depth does not fit the address width.");
  end

  // The array has no reset so that it maps onto plain RAM.
  always_ff @(posedge clk) begin
    if (port.wrEn && (int'(port.wrAddr) < DEPTH)) begin
      mem[port.wrAddr] <= port.wrData;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData_reg <= '0;
    end else if (int'(port.rdAddr) < DEPTH) begin
      rdData_reg <= mem[port.rdAddr];
    end else begin
      rdData_reg <= '0;
    end
  end

  assign port.rdData = rdData_reg;

endmodule : program_store

`default_nettype wire

// ---- hw/event_action_sequencer.sv ----
/*
  Event/action sequencer: steps through programmed event/action pairs, one event per
  scan tick, and drives the speed reference, timer 0 and the stop ramp indication.
  Assumes scanTick and the programming port come from logic on clk; the three motor
  status pins are asynchronous and are synchronised here.
*/
`timescale 1ns/100ps
`default_nettype none

module event_action_sequencer #(
  parameter int MAX_PAIRS = event_action_sequencer_pkg::MAX_PAIRS_DEF,
  parameter int MS_CYCLES = event_action_sequencer_pkg::MS_CYCLES
) (
  input  wire logic                                         clk,
  input  wire logic                                         rst_b,
  input  wire logic                                         seqEnable,
  input  wire logic [event_action_sequencer_pkg::COUNT_W-1:0] pairCount,
  input  wire logic                                         scanTick,
  input  wire logic                                         progWrEn,
  input  wire logic [event_action_sequencer_pkg::COUNT_W-1:0] progAddr,
  input  wire logic [event_action_sequencer_pkg::CODE_W-1:0]  progEventCode,
  input  wire logic [event_action_sequencer_pkg::CODE_W-1:0]  progActionCode,
  input  wire logic [event_action_sequencer_pkg::PCT_W-1:0]   presetRef0,
  input  wire logic [event_action_sequencer_pkg::PCT_W-1:0]   presetRef1,
  input  wire logic [event_action_sequencer_pkg::TIMER_W-1:0] timer0DurationMs,
  input  wire logic                                         speedAtRefPin,
  input  wire logic                                         stopPin,
  input  wire logic                                         zeroSpeedPin,
  output logic      [event_action_sequencer_pkg::PCT_W-1:0]   speedRef,
  output logic      [event_action_sequencer_pkg::COUNT_W-1:0] pairIndex,
  output logic                                              actionPulse,
  output logic                                              seqRunning,
  output logic                                              timer0Running,
  output logic                                              timer0Expired,
  output logic                                              rampDown,
  output logic                                              freeState
);

  localparam int CW = event_action_sequencer_pkg::COUNT_W;
  localparam int DW = event_action_sequencer_pkg::CODE_W;
  localparam int PW = event_action_sequencer_pkg::PCT_W;
  localparam int TW = event_action_sequencer_pkg::TIMER_W;
  localparam int SB = event_action_sequencer_pkg::SYNC_BITS;
  localparam int MSW = $clog2(MS_CYCLES + 1);
  localparam logic [CW-1:0] MAX_PAIRS_C = CW'(MAX_PAIRS);
  localparam logic [MSW-1:0] MS_LAST = MSW'(MS_CYCLES - 1);

  if (MAX_PAIRS < 1 || MAX_PAIRS >= (1 << CW)) begin : badPairs
    $error("MAX_PAIRS must lie between 1 and the pair counter range.");
  end
  if (MS_CYCLES < 1) begin : badMs
    $error("MS_CYCLES must be at least one.");
  end

  // Pin synchronisers: only the second stage is read by logic.
  logic [SB-1:0] syncA_reg;
  logic [SB-1:0] syncB_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      syncA_reg <= '0;
      syncB_reg <= '0;
    end else begin
      syncA_reg <= {zeroSpeedPin, stopPin, speedAtRefPin};
      syncB_reg <= syncA_reg;
    end
  end

  logic atRef;
  logic stopCmd;
  logic zeroSpeed;
  assign atRef     = syncB_reg[0];
  assign stopCmd   = syncB_reg[1];
  assign zeroSpeed = syncB_reg[2];

  // Program store.
  seq_prog_if #(.AW(CW), .DW(2 * DW)) prog ();

  program_store #(
    .DEPTH (MAX_PAIRS),
    .AW    (CW),
    .DW    (2 * DW)
  ) store (
    .clk   (clk),
    .rst_b (rst_b),
    .port  (prog)
  );

  logic [CW-1:0] ptr_reg;

  assign prog.wrEn   = progWrEn;
  assign prog.wrAddr = progAddr;
  assign prog.wrData = {progEventCode, progActionCode};
  assign prog.rdAddr = ptr_reg;

  logic [DW-1:0] curEvent;
  logic [DW-1:0] curAction;
  assign curEvent  = prog.rdData[2*DW-1:DW];
  assign curAction = prog.rdData[DW-1:0];

  // Pair counts above the store depth are served as the full depth.
  logic [CW-1:0] usedPairs;
  assign usedPairs = (pairCount > MAX_PAIRS_C) ? MAX_PAIRS_C : pairCount;

  logic active;
  assign active = seqEnable && (usedPairs != '0);

  // Event decode of the single current pair.
  logic timerExpired_reg;
  logic eventTrue;

  always_comb begin
    case (curEvent)
      event_action_sequencer_pkg::EV_FALSE:    eventTrue = 1'b0;
      event_action_sequencer_pkg::EV_TRUE:     eventTrue = 1'b1;
      event_action_sequencer_pkg::EV_AT_REF:   eventTrue = atRef;
      event_action_sequencer_pkg::EV_TIMEOUT0: eventTrue = timerExpired_reg;
      default:                                 eventTrue = 1'b0;
    endcase
  end

  // Sequencer state machine.
  event_action_sequencer_pkg::seq_state_type state_reg;
  event_action_sequencer_pkg::seq_state_type state_next;
  logic fire;

  // An event is judged only in READY, on a tick, and only for the current pair.
  assign fire = (state_reg == event_action_sequencer_pkg::SEQ_READY)
                && active && scanTick && eventTrue;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      event_action_sequencer_pkg::SEQ_IDLE: begin
        if (active) begin
          state_next = event_action_sequencer_pkg::SEQ_FETCH;
        end
      end
      event_action_sequencer_pkg::SEQ_FETCH: begin
        if (!active) begin
          state_next = event_action_sequencer_pkg::SEQ_IDLE;
        end else begin
          state_next = event_action_sequencer_pkg::SEQ_READY;
        end
      end
      event_action_sequencer_pkg::SEQ_READY: begin
        if (!active) begin
          state_next = event_action_sequencer_pkg::SEQ_IDLE;
        end else if (fire) begin
          state_next = event_action_sequencer_pkg::SEQ_FETCH;
        end
      end
      default: state_next = event_action_sequencer_pkg::SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= event_action_sequencer_pkg::SEQ_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Pair pointer; a tick that lands in FETCH is skipped, which costs one scan at most.
  logic [CW-1:0] ptr_next;

  always_comb begin
    if ((ptr_reg + CW'(1)) >= usedPairs) begin
      ptr_next = '0;
    end else begin
      ptr_next = ptr_reg + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_reg <= '0;
    end else if (!active) begin
      ptr_reg <= '0;
    end else if (fire) begin
      ptr_reg <= ptr_next;
    end
  end

  // Action execution.
  logic actPulse_reg;
  logic [PW-1:0] speedRef_reg;
  logic startTimer;

  assign startTimer = fire && (curAction == event_action_sequencer_pkg::ACT_START_TMR);

  function automatic logic [PW-1:0] clampPct(input logic [PW-1:0] v);
    clampPct = (v > event_action_sequencer_pkg::PCT_MAX)
               ? event_action_sequencer_pkg::PCT_MAX : v;
  endfunction : clampPct

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      speedRef_reg <= event_action_sequencer_pkg::SPEED_RESET;
    end else if (fire) begin
      case (curAction)
        event_action_sequencer_pkg::ACT_PRESET0: speedRef_reg <= clampPct(presetRef0);
        event_action_sequencer_pkg::ACT_PRESET1: speedRef_reg <= clampPct(presetRef1);
        default:                                 speedRef_reg <= speedRef_reg;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      actPulse_reg <= 1'b0;
    end else begin
      actPulse_reg <= fire;
    end
  end

  // Timer 0, counted in milliseconds.
  logic [MSW-1:0] msCnt_reg;
  logic [TW-1:0]  remain_reg;
  logic           timerRun_reg;
  logic           msWrap;
  logic           timeUp;

  assign msWrap = (msCnt_reg == MS_LAST);
  assign timeUp = (remain_reg == event_action_sequencer_pkg::TIMER_ZERO)
                  || (msWrap && (remain_reg == TW'(1)));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      msCnt_reg        <= '0;
      remain_reg       <= event_action_sequencer_pkg::TIMER_ZERO;
      timerRun_reg     <= 1'b0;
      timerExpired_reg <= 1'b0;
    end else if (startTimer) begin
      msCnt_reg        <= '0;
      remain_reg       <= timer0DurationMs;
      timerRun_reg     <= 1'b1;
      timerExpired_reg <= 1'b0;
    end else if (timerRun_reg) begin
      if (timeUp) begin
        timerRun_reg     <= 1'b0;
        timerExpired_reg <= 1'b1;
      end else if (msWrap) begin
        msCnt_reg  <= '0;
        remain_reg <= remain_reg - TW'(1);
      end else begin
        msCnt_reg <= msCnt_reg + MSW'(1);
      end
    end
  end

  // Stop handling is independent of the pair pointer.
  logic rampDown_reg;
  logic freeState_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rampDown_reg  <= 1'b0;
      freeState_reg <= 1'b0;
    end else begin
      rampDown_reg  <= stopCmd && !freeState_reg;
      freeState_reg <= stopCmd && (freeState_reg || zeroSpeed);
    end
  end

  logic seqRun_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seqRun_reg <= 1'b0;
    end else begin
      seqRun_reg <= active;
    end
  end

  assign speedRef      = speedRef_reg;
  assign pairIndex     = ptr_reg;
  assign actionPulse   = actPulse_reg;
  assign seqRunning    = seqRun_reg;
  assign timer0Running = timerRun_reg;
  assign timer0Expired = timerExpired_reg;
  assign rampDown      = rampDown_reg;
  assign freeState     = freeState_reg;

endmodule : event_action_sequencer

`default_nettype wire

// ---- tb/event_action_sequencer_chk.sv ----
/*
  Port-level assertions for the event/action sequencer.
  Assumes it is bound to the design's top module, on clk with active-low rst_b.
*/
`timescale 1ns/100ps
`default_nettype none

module event_action_sequencer_chk (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       seqEnable,
  input wire logic [4:0] pairCount,
  input wire logic       scanTick,
  input wire logic       stopPin,
  input wire logic       zeroSpeedPin,
  input wire logic [6:0] speedRef,
  input wire logic [4:0] pairIndex,
  input wire logic       actionPulse,
  input wire logic       seqRunning,
  input wire logic       timer0Running,
  input wire logic       timer0Expired,
  input wire logic       rampDown,
  input wire logic       freeState
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  AST_PULSE_ONE: assert property (actionPulse |=> !actionPulse)
    else $error("action pulse lasted more than one cycle");
  AST_FIRE_CAUSE: assert property (actionPulse |-> $past(seqEnable) && $past(scanTick))
    else $error("action fired without enable and tick");
  // Counts above twenty are left out because they saturate and would need their own model.
  AST_ADVANCE: assert property (actionPulse && $stable(pairCount) && pairCount != 5'h00 &&
    pairCount <= 5'h14 |-> pairIndex == (($past(pairIndex) + 5'h01 == pairCount) ? 5'h00
    : $past(pairIndex) + 5'h01)) else $error("pair index did not advance or wrap");
  AST_ZERO_IDLE: assert property (pairCount == 5'h00 ##1 pairCount == 5'h00 |=>
    !actionPulse && pairIndex == 5'h00) else $error("activity with zero pairs");
  AST_DISABLE_IDLE: assert property (!seqEnable ##1 !seqEnable |=>
    pairIndex == 5'h00 && !seqRunning && !actionPulse) else $error("active while disabled");
  AST_RUNNING: assert property (1'b1 |=> seqRunning == $past(seqEnable && pairCount != 5'h00))
    else $error("running flag wrong");
  AST_TMR_START: assert property ($rose(timer0Running) |-> actionPulse && !timer0Expired)
    else $error("timer started without an action");
  AST_TMR_EXPIRE: assert property ($fell(timer0Running) |-> timer0Expired)
    else $error("timer stopped without expiry");
  AST_SPEED_HOLD: assert property (!$stable(speedRef) |-> actionPulse)
    else $error("speed reference moved without an action");
  AST_RAMP: assert property ($rose(rampDown) |-> $past(stopPin, 3))
    else $error("ramp down without stop");
  AST_FREE: assert property ($rose(freeState) |-> rampDown && $past(zeroSpeedPin, 3))
    else $error("free state without ramp and zero speed");
  AST_RAMP_END: assert property ($rose(freeState) |=> !rampDown)
    else $error("ramp down held in free state");
endmodule : event_action_sequencer_chk

`default_nettype wire

// ---- tb/event_action_sequencer_bench.sv ----
/*
  Self-checking bench for the event/action sequencer, with its checker bound in.
  Assumes the package and design files are compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none

module event_action_sequencer_bench;
  logic        clk, rst_b, seqEnable, scanTick, progWrEn, speedAtRefPin, stopPin, zeroSpeedPin;
  logic        actionPulse, seqRunning, timer0Running, timer0Expired, rampDown, freeState, f;
  logic [4:0]  pairCount, progAddr, pairIndex;
  logic [7:0]  progEventCode, progActionCode;
  logic [6:0]  presetRef0, presetRef1, speedRef;
  logic [15:0] timer0DurationMs;
  int          mismatches = 0;
  int          cmpCount = 0;
  int          cycles = 0;

  // A short millisecond keeps timer runs to tens of cycles.
  event_action_sequencer #(.MS_CYCLES(4)) dut (.clk, .rst_b, .seqEnable, .pairCount, .scanTick,
    .progWrEn, .progAddr, .progEventCode, .progActionCode, .presetRef0, .presetRef1,
    .timer0DurationMs, .speedAtRefPin, .stopPin, .zeroSpeedPin, .speedRef, .pairIndex,
    .actionPulse, .seqRunning, .timer0Running, .timer0Expired, .rampDown, .freeState);

  task automatic chk(input string what, input logic [6:0] exp, input logic [6:0] got);
    cmpCount++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic printVerdict;
    $display("Comparisons %0d, mismatches %0d", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : printVerdict

  // The strobe is left high so back-to-back writes never assign it twice at one instant.
  task automatic prog(input logic [4:0] a, input logic [7:0] e, input logic [7:0] c);
    progAddr = a;
    progEventCode = e;
    progActionCode = c;
    progWrEn = 1'b1;
    @(posedge clk);
    #1;
  endtask : prog

  task automatic tick(output logic fired);
    repeat (3) @(posedge clk);
    #1 scanTick = 1'b1;
    @(posedge clk);
    #1 scanTick = 1'b0;
    fired = actionPulse;
    repeat (3) @(posedge clk);
    #1;
  endtask : tick

  task automatic scenExample;
    int n;
    prog(5'h00, 8'h01, 8'h0A);
    prog(5'h01, 8'h04, 8'h1D);
    prog(5'h02, 8'h1E, 8'h0B);
    prog(5'h03, 8'h00, 8'h01);
    progWrEn = 1'b0;
    pairCount = 5'h04;
    seqEnable = 1'b1;
    tick(f);
    chk("fired", 7'h01, 7'(f));
    chk("speedRef", 7'h3C, speedRef);
    chk("pairIndex", 7'h01, 7'(pairIndex));
    tick(f);
    chk("fired", 7'h00, 7'(f));
    chk("pairIndex", 7'h01, 7'(pairIndex));
    speedAtRefPin = 1'b1;
    tick(f);
    chk("fired", 7'h01, 7'(f));
    chk("timer0Running", 7'h01, 7'(timer0Running));
    tick(f);
    chk("fired", 7'h00, 7'(f));
    // The timer started ten edges ago; five periods of four cycles leave ten more to wait.
    n = 0;
    while (timer0Expired !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("timer0Wait", 7'h0A, 7'(n));
    chk("timer0Expired", 7'h01, 7'(timer0Expired));
    chk("timer0Running", 7'h00, 7'(timer0Running));
    tick(f);
    chk("fired", 7'h01, 7'(f));
    chk("speedRef", 7'h00, speedRef);
    tick(f);
    chk("fired", 7'h00, 7'(f));
    chk("pairIndex", 7'h03, 7'(pairIndex));
  endtask : scenExample

  task automatic scenWrap;
    seqEnable = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("pairIndex", 7'h00, 7'(pairIndex));
    chk("seqRunning", 7'h00, 7'(seqRunning));
    prog(5'h00, 8'h00, 8'h0B);
    prog(5'h01, 8'h01, 8'h0A);
    progWrEn = 1'b0;
    pairCount = 5'h02;
    presetRef0 = 7'h7F;
    seqEnable = 1'b1;
    tick(f);
    tick(f);
    chk("fired", 7'h00, 7'(f));
    chk("pairIndex", 7'h00, 7'(pairIndex));
    seqEnable = 1'b0;
    prog(5'h00, 8'h01, 8'h01);
    progWrEn = 1'b0;
    seqEnable = 1'b1;
    tick(f);
    chk("pairIndex", 7'h01, 7'(pairIndex));
    chk("speedRef", 7'h00, speedRef);
    tick(f);
    chk("fired", 7'h01, 7'(f));
    chk("pairIndex", 7'h00, 7'(pairIndex));
    chk("speedRef", 7'h64, speedRef);
  endtask : scenWrap

  task automatic scenZeroAndStop;
    pairCount = 5'h00;
    tick(f);
    chk("fired", 7'h00, 7'(f));
    chk("speedRef", 7'h64, speedRef);
    chk("seqRunning", 7'h00, 7'(seqRunning));
    stopPin = 1'b1;
    repeat (5) @(posedge clk);
    #1 chk("rampDown", 7'h01, 7'(rampDown));
    zeroSpeedPin = 1'b1;
    repeat (5) @(posedge clk);
    #1 chk("freeState", 7'h01, 7'(freeState));
    chk("rampDown", 7'h00, 7'(rampDown));
    stopPin = 1'b0;
    zeroSpeedPin = 1'b0;
    repeat (5) @(posedge clk);
    #1 chk("freeState", 7'h00, 7'(freeState));
    // A reset with the sequencer idle (no pairs) must drop the held reference and keep the running flag low.
    rst_b = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    chk("speedRef", 7'h00, speedRef);
    chk("pairIndex", 7'h00, 7'(pairIndex));
    chk("seqRunning", 7'h00, 7'(seqRunning));
  endtask : scenZeroAndStop

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      printVerdict();
    end
  end

  initial begin
    rst_b = 1'b0;
    {seqEnable, scanTick, progWrEn, speedAtRefPin, stopPin, zeroSpeedPin} = 6'h00;
    pairCount = 5'h00;
    progAddr = 5'h00;
    progEventCode = 8'h00;
    progActionCode = 8'h00;
    presetRef0 = 7'h3C;
    presetRef1 = 7'h00;
    timer0DurationMs = 16'h0005;
    repeat (3) @(posedge clk);
    #1 rst_b = 1'b1;
    chk("speedRef", 7'h00, speedRef);
    chk("pairIndex", 7'h00, 7'(pairIndex));
    scenExample();
    scenWrap();
    scenZeroAndStop();
    printVerdict();
  end
endmodule : event_action_sequencer_bench

bind event_action_sequencer event_action_sequencer_chk chk_i (.clk, .rst_b, .seqEnable,
  .pairCount, .scanTick, .stopPin, .zeroSpeedPin, .speedRef, .pairIndex, .actionPulse,
  .seqRunning, .timer0Running, .timer0Expired, .rampDown, .freeState);

`default_nettype wire
